/* core/cfse_map.svh */
// Constant map for the flag, shift and load execution unit
`ifndef CFSE_MAP_SVH
`define CFSE_MAP_SVH
`define CFSE_FLAG_C 3'h0
`define CFSE_FLAG_Z 3'h1
`define CFSE_FLAG_N 3'h2
`define CFSE_FLAG_V 3'h3
`define CFSE_FLAG_S 3'h4
`define CFSE_FLAG_H 3'h5
`define CFSE_FLAG_T 3'h6
`define CFSE_FLAG_I 3'h7
`define CFSE_PTR_X_LO 5'h1A
`define CFSE_PTR_X_HI 5'h1B
`define CFSE_PTR_Y_LO 5'h1C
`define CFSE_PTR_Y_HI 5'h1D
`define CFSE_PC_RESET 16'h0000
`define CFSE_FLAGS_RESET 8'h00
`define CFSE_RF_RESET 8'h00
`define CFSE_WORD_STEP 16'h0001
`endif

/* core/cfse_pkg.sv */
// Types for the flag, shift and load execution unit
package cfse_pkg;
  typedef enum logic [4:0] {
    op_nop,
    branch_on_transfer_clear,
    branch_on_overflow_high,
    branch_on_overflow_low,
    branch_on_irq_on,
    branch_on_irq_off,
    io_bit_set_instr,
    io_bit_clear_instr,
    logical_shift_left,
    logical_shift_right,
    rotate_left_carry,
    rotate_right_carry,
    arith_shift_right,
    swap_nibbles,
    status_flag_set_instr,
    status_flag_clear_instr,
    global_irq_enable_instr,
    global_irq_disable_instr,
    store_bit_to_transfer_flag,
    fetch_bit_from_transfer_flag,
    copy_register,
    copy_register_pair,
    load_immediate,
    load_indirect_x,
    load_indirect_x_post_inc,
    load_indirect_x_pre_dec,
    load_indirect_y,
    load_indirect_y_post_inc,
    load_indirect_y_pre_dec
  } cfse_op_t;
  typedef enum logic {
    st_issue,
    st_second
  } cfse_state_t;
endpackage

/* core/cfse_exec.sv */
// Execution unit for branches, bit ops, shifts, flag ops, moves and indirect loads
`timescale 1ns/10ps
`default_nettype none
`include "cfse_map.svh"
//
// Contract
// - Branch on transfer clear: offset plus one
// - Overflow branches jump, flags untouched
// - Interrupt-state branches jump, one or two cycles
// - IO bit set/clear, two cycles, flags kept
// - Left shift, zero into bit 0
// - Right shift, zero into bit 7
// - Rotate left through carry
// - Rotate right through carry
// - Arithmetic right shift keeps sign bit
// - Flag set/clear changes only that flag
// - Register bit copied into transfer flag
// - Transfer flag copied into register bit
// - Post-increment load: read, then pointer plus one
// - Pre-decrement load: pointer minus one, then read
module cfse_exec (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire cfse_pkg::cfse_op_t instr_op,
  input wire logic [4:0] instr_rd,
  input wire logic [4:0] instr_rr,
  input wire logic [2:0] instr_bit,
  input wire logic [7:0] instr_imm,
  input wire logic [6:0] instr_offset,
  input wire logic [4:0] instr_io_addr,
  output logic instr_ready,
  output logic [15:0] pc,
  output logic [7:0] status_flags,
  output logic [15:0] dmem_addr,
  output logic dmem_rd_en,
  input wire logic [7:0] dmem_rdata,
  output logic [4:0] io_addr,
  output logic io_rd_en,
  input wire logic [7:0] io_rdata,
  output logic io_wr_en,
  output logic [7:0] io_wdata,
  input wire logic [4:0] rf_dbg_addr,
  output logic [7:0] rf_dbg_data
);
  import cfse_pkg::*;

  cfse_state_t state_reg, state_next;
  cfse_op_t pend_op_reg, pend_op_next;
  logic [15:0] pc_reg, pc_next;
  logic [7:0] flags_reg, flags_next;
  logic [7:0] rf_reg [32];
  logic [7:0] rf_next [32];
  logic [4:0] pend_rd_reg, pend_rd_next;
  logic [4:0] pend_lo_reg, pend_lo_next;
  logic [2:0] pend_bit_reg, pend_bit_next;
  logic [15:0] aux_reg, aux_next;
  logic [15:0] dmem_addr_reg, dmem_addr_next;
  logic dmem_rd_en_reg, dmem_rd_en_next;
  logic [4:0] io_addr_reg, io_addr_next;
  logic io_rd_en_reg, io_rd_en_next;
  logic io_wr_en_reg, io_wr_en_next;
  logic [7:0] io_wdata_reg, io_wdata_next;
  logic [7:0] rf_dbg_reg;
  logic accept;
  logic [7:0] rd_val;
  logic [7:0] shift_res;
  logic shift_c;
  logic is_shift;
  logic br_cond;
  logic is_branch;
  logic is_load;
  logic use_y;
  logic [4:0] ptr_lo;
  logic [4:0] ptr_hi;
  logic [15:0] ptr_val;
  logic [15:0] br_target;

  assign instr_ready = (state_reg == st_issue);
  assign accept = instr_valid && instr_ready;
  assign rd_val = rf_reg[instr_rd];
  assign use_y = (instr_op == load_indirect_y) || (instr_op == load_indirect_y_post_inc)
    || (instr_op == load_indirect_y_pre_dec);
  assign ptr_lo = use_y ? `CFSE_PTR_Y_LO : `CFSE_PTR_X_LO;
  assign ptr_hi = use_y ? `CFSE_PTR_Y_HI : `CFSE_PTR_X_HI;
  assign ptr_val = {rf_reg[ptr_hi], rf_reg[ptr_lo]};
  assign br_target = pc_reg + `CFSE_WORD_STEP + {{9{instr_offset[6]}}, instr_offset};
  assign is_load = (instr_op >= load_indirect_x) && (instr_op <= load_indirect_y_pre_dec);
  assign is_shift = (instr_op >= logical_shift_left) && (instr_op <= arith_shift_right);
  assign pc = pc_reg;
  assign status_flags = flags_reg;
  assign dmem_addr = dmem_addr_reg;
  assign dmem_rd_en = dmem_rd_en_reg;
  assign io_addr = io_addr_reg;
  assign io_rd_en = io_rd_en_reg;
  assign io_wr_en = io_wr_en_reg;
  assign io_wdata = io_wdata_reg;
  assign rf_dbg_data = rf_dbg_reg;

  // Shift and rotate results
  always_comb
  begin
    shift_res = rd_val;
    shift_c = flags_reg[`CFSE_FLAG_C];
    case (instr_op)
      logical_shift_left:
      begin
        shift_res = {rd_val[6:0], 1'h0};
        shift_c = rd_val[7];
      end
      logical_shift_right:
      begin
        shift_res = {1'h0, rd_val[7:1]};
        shift_c = rd_val[0];
      end
      rotate_left_carry:
      begin
        shift_res = {rd_val[6:0], flags_reg[`CFSE_FLAG_C]};
        shift_c = rd_val[7];
      end
      rotate_right_carry:
      begin
        shift_res = {flags_reg[`CFSE_FLAG_C], rd_val[7:1]};
        shift_c = rd_val[0];
      end
      arith_shift_right:
      begin
        shift_res = {rd_val[7], rd_val[7:1]};
        shift_c = rd_val[0];
      end
      default:
      begin
        shift_res = rd_val;
        shift_c = flags_reg[`CFSE_FLAG_C];
      end
    endcase
  end

  // Branch conditions
  always_comb
  begin
    is_branch = 1'h1;
    br_cond = 1'h0;
    case (instr_op)
      branch_on_transfer_clear: br_cond = !flags_reg[`CFSE_FLAG_T];
      branch_on_overflow_high: br_cond = flags_reg[`CFSE_FLAG_V];
      branch_on_overflow_low: br_cond = !flags_reg[`CFSE_FLAG_V];
      branch_on_irq_on: br_cond = flags_reg[`CFSE_FLAG_I];
      branch_on_irq_off: br_cond = !flags_reg[`CFSE_FLAG_I];
      default: is_branch = 1'h0;
    endcase
  end

  // Next-state logic
  always_comb
  begin
    state_next = state_reg;
    pend_op_next = pend_op_reg;
    pc_next = pc_reg;
    flags_next = flags_reg;
    rf_next = rf_reg;
    pend_rd_next = pend_rd_reg;
    pend_lo_next = pend_lo_reg;
    pend_bit_next = pend_bit_reg;
    aux_next = aux_reg;
    dmem_addr_next = dmem_addr_reg;
    dmem_rd_en_next = 1'h0;
    io_addr_next = io_addr_reg;
    io_rd_en_next = 1'h0;
    io_wr_en_next = 1'h0;
    io_wdata_next = io_wdata_reg;
    if (state_reg == st_second)
    begin
      state_next = st_issue;
      pc_next = pc_reg + `CFSE_WORD_STEP;
      case (pend_op_reg)
        io_bit_set_instr:
        begin
          io_wdata_next = io_rdata;
          io_wdata_next[pend_bit_reg] = 1'h1;
          io_wr_en_next = 1'h1;
        end
        io_bit_clear_instr:
        begin
          io_wdata_next = io_rdata;
          io_wdata_next[pend_bit_reg] = 1'h0;
          io_wr_en_next = 1'h1;
        end
        load_indirect_x, load_indirect_y, load_indirect_x_pre_dec, load_indirect_y_pre_dec:
          rf_next[pend_rd_reg] = dmem_rdata;
        load_indirect_x_post_inc, load_indirect_y_post_inc:
        begin
          rf_next[pend_rd_reg] = dmem_rdata;
          rf_next[pend_lo_reg] = aux_reg[7:0];
          rf_next[pend_lo_reg + 5'h01] = aux_reg[15:8];
        end
        default: pc_next = aux_reg;
      endcase
    end
    else if (accept)
    begin
      pc_next = pc_reg + `CFSE_WORD_STEP;
      pend_op_next = instr_op;
      pend_rd_next = instr_rd;
      pend_lo_next = ptr_lo;
      pend_bit_next = instr_bit;
      if (is_branch)
      begin
        if (br_cond)
        begin
          state_next = st_second;
          pc_next = pc_reg;
          aux_next = br_target;
        end
      end
      else if (is_shift)
      begin
        rf_next[instr_rd] = shift_res;
        flags_next[`CFSE_FLAG_C] = shift_c;
        flags_next[`CFSE_FLAG_Z] = (shift_res == 8'h00);
        flags_next[`CFSE_FLAG_N] = shift_res[7];
        flags_next[`CFSE_FLAG_V] = shift_res[7] ^ shift_c;
      end
      else if (is_load)
      begin
        state_next = st_second;
        pc_next = pc_reg;
        dmem_rd_en_next = 1'h1;
        dmem_addr_next = ptr_val;
        aux_next = ptr_val + `CFSE_WORD_STEP;
        if ((instr_op == load_indirect_x_pre_dec) || (instr_op == load_indirect_y_pre_dec))
        begin
          dmem_addr_next = ptr_val - `CFSE_WORD_STEP;
          rf_next[ptr_lo] = dmem_addr_next[7:0];
          rf_next[ptr_hi] = dmem_addr_next[15:8];
        end
      end
      else
      begin
        case (instr_op)
          io_bit_set_instr, io_bit_clear_instr:
          begin
            state_next = st_second;
            pc_next = pc_reg;
            io_addr_next = instr_io_addr;
            io_rd_en_next = 1'h1;
          end
          swap_nibbles: rf_next[instr_rd] = {rd_val[3:0], rd_val[7:4]};
          status_flag_set_instr: flags_next[instr_bit] = 1'h1;
          status_flag_clear_instr: flags_next[instr_bit] = 1'h0;
          global_irq_enable_instr: flags_next[`CFSE_FLAG_I] = 1'h1;
          global_irq_disable_instr: flags_next[`CFSE_FLAG_I] = 1'h0;
          store_bit_to_transfer_flag: flags_next[`CFSE_FLAG_T] = rd_val[instr_bit];
          fetch_bit_from_transfer_flag: rf_next[instr_rd][instr_bit] = flags_reg[`CFSE_FLAG_T];
          copy_register: rf_next[instr_rd] = rf_reg[instr_rr];
          copy_register_pair:
          begin
            rf_next[{instr_rd[4:1], 1'h0}] = rf_reg[{instr_rr[4:1], 1'h0}];
            rf_next[{instr_rd[4:1], 1'h1}] = rf_reg[{instr_rr[4:1], 1'h1}];
          end
          load_immediate: rf_next[instr_rd] = instr_imm;
          default: pc_next = pc_reg + `CFSE_WORD_STEP;
        endcase
      end
    end
  end

  // State registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= st_issue;
      pend_op_reg <= op_nop;
      pc_reg <= `CFSE_PC_RESET;
      flags_reg <= `CFSE_FLAGS_RESET;
      for (int i = 0; i < 32; i++)
      begin
        rf_reg[i] <= `CFSE_RF_RESET;
      end
      pend_rd_reg <= 5'h00;
      pend_lo_reg <= 5'h00;
      pend_bit_reg <= 3'h0;
      aux_reg <= `CFSE_PC_RESET;
      dmem_addr_reg <= 16'h0000;
      dmem_rd_en_reg <= 1'h0;
      io_addr_reg <= 5'h00;
      io_rd_en_reg <= 1'h0;
      io_wr_en_reg <= 1'h0;
      io_wdata_reg <= 8'h00;
      rf_dbg_reg <= `CFSE_RF_RESET;
    end
    else
    begin
      state_reg <= state_next;
      pend_op_reg <= pend_op_next;
      pc_reg <= pc_next;
      flags_reg <= flags_next;
      rf_reg <= rf_next;
      pend_rd_reg <= pend_rd_next;
      pend_lo_reg <= pend_lo_next;
      pend_bit_reg <= pend_bit_next;
      aux_reg <= aux_next;
      dmem_addr_reg <= dmem_addr_next;
      dmem_rd_en_reg <= dmem_rd_en_next;
      io_addr_reg <= io_addr_next;
      io_rd_en_reg <= io_rd_en_next;
      io_wr_en_reg <= io_wr_en_next;
      io_wdata_reg <= io_wdata_next;
      rf_dbg_reg <= rf_reg[rf_dbg_addr];
    end
  end

  property p_tclr_br_taken;
    @(posedge sys_clk) disable iff (!rst_n)
    accept && instr_op == branch_on_transfer_clear && !flags_reg[`CFSE_FLAG_T]
    |=> !instr_ready ##1 pc_reg == $past(br_target, 2);
  endproperty
  a_tclr_br_taken: assert property (p_tclr_br_taken) else $error("transfer-clear branch target wrong");

  property p_brv_flags;
    @(posedge sys_clk) disable iff (!rst_n)
    accept && (instr_op == branch_on_overflow_high || instr_op == branch_on_overflow_low)
    |=> flags_reg == $past(flags_reg) ##1 ($past(accept) || flags_reg == $past(flags_reg, 2));
  endproperty
  a_brv_flags: assert property (p_brv_flags) else $error("overflow branch changed flags");

  property p_irq_on_br_fall;
    @(posedge sys_clk) disable iff (!rst_n)
    accept && instr_op == branch_on_irq_on && !flags_reg[`CFSE_FLAG_I]
    |=> instr_ready && pc_reg == $past(pc_reg) + `CFSE_WORD_STEP;
  endproperty
  a_irq_on_br_fall: assert property (p_irq_on_br_fall) else $error("untaken irq branch not one cycle");

  property p_io_set;
    @(posedge sys_clk) disable iff (!rst_n)
    accept && instr_op == io_bit_set_instr
    |=> io_rd_en_reg ##1 io_wr_en_reg && io_wdata_reg[$past(instr_bit, 2)] && flags_reg == $past(flags_reg, 2);
  endproperty
  a_io_set: assert property (p_io_set) else $error("io bit set wrong");

  property p_shl;
    @(posedge sys_clk) disable iff (!rst_n)
    accept && instr_op == logical_shift_left
    |=> rf_reg[$past(instr_rd)] == {$past(rd_val[6:0]), 1'h0} && flags_reg[`CFSE_FLAG_C] == $past(rd_val[7]);
  endproperty
  a_shl: assert property (p_shl) else $error("left shift wrong");

  property p_ror;
    @(posedge sys_clk) disable iff (!rst_n)
    accept && instr_op == rotate_right_carry
    |=> rf_reg[$past(instr_rd)][7] == $past(flags_reg[`CFSE_FLAG_C]) && flags_reg[`CFSE_FLAG_C] == $past(rd_val[0]);
  endproperty
  a_ror: assert property (p_ror) else $error("rotate right wrong");

  property p_sar;
    @(posedge sys_clk) disable iff (!rst_n)
    accept && instr_op == arith_shift_right
    |=> rf_reg[$past(instr_rd)][7:6] == {2{$past(rd_val[7])}};
  endproperty
  a_sar: assert property (p_sar) else $error("sign not kept");

  property p_tflag_store;
    @(posedge sys_clk) disable iff (!rst_n)
    accept && instr_op == store_bit_to_transfer_flag
    |=> flags_reg[`CFSE_FLAG_T] == $past(rd_val[instr_bit]);
  endproperty
  a_tflag_store: assert property (p_tflag_store) else $error("transfer flag not stored");

  property p_load_post_inc;
    @(posedge sys_clk) disable iff (!rst_n)
    accept && instr_op == load_indirect_x_post_inc && instr_rd < `CFSE_PTR_X_LO
    |=> dmem_rd_en_reg && dmem_addr_reg == $past(ptr_val)
    ##1 instr_ready && {rf_reg[`CFSE_PTR_X_HI], rf_reg[`CFSE_PTR_X_LO]} == $past(ptr_val, 2) + `CFSE_WORD_STEP;
  endproperty
  a_load_post_inc: assert property (p_load_post_inc) else $error("post-increment load wrong");
endmodule
`default_nettype wire

/* tb/cpu_flag_shift_load_exec_tb_top.sv */
// Self-checking bench for the flag, shift and load execution unit
`timescale 1ns/10ps
`default_nettype none
`include "cfse_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cpu_flag_shift_load_exec_tb_top;
  import cfse_pkg::*;
  logic sys_clk, rst_n, instr_valid, instr_ready, dmem_rd_en, io_rd_en, io_wr_en, wr_seen;
  cfse_op_t instr_op;
  logic [4:0] instr_rd, instr_rr, instr_io_addr, io_addr, rf_dbg_addr;
  logic [2:0] instr_bit;
  logic [7:0] instr_imm, status_flags, dmem_rdata, io_rdata, io_wdata, rf_dbg_data, sf_exp, wd_seen;
  logic [6:0] instr_offset;
  logic [15:0] pc, dmem_addr, pc_exp, e;
  logic [7:0] io_mem [32];
  int num_errors, n_tests, i, p, tk;
  cfse_op_t sops [6] = '{logical_shift_left, logical_shift_right, rotate_left_carry, rotate_right_carry,
    arith_shift_right, swap_nibbles};
  cfse_op_t bops [5] = '{branch_on_transfer_clear, branch_on_overflow_high, branch_on_overflow_low,
    branch_on_irq_on, branch_on_irq_off};
  logic [2:0] bfl [5] = '{`CFSE_FLAG_T, `CFSE_FLAG_V, `CFSE_FLAG_V, `CFSE_FLAG_I, `CFSE_FLAG_I};
  bit bwh [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  cfse_exec dut (.sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_rd(instr_rd), .instr_rr(instr_rr), .instr_bit(instr_bit), .instr_imm(instr_imm),
    .instr_offset(instr_offset), .instr_io_addr(instr_io_addr), .instr_ready(instr_ready), .pc(pc),
    .status_flags(status_flags), .dmem_addr(dmem_addr), .dmem_rd_en(dmem_rd_en), .dmem_rdata(dmem_rdata),
    .io_addr(io_addr), .io_rd_en(io_rd_en), .io_rdata(io_rdata), .io_wr_en(io_wr_en), .io_wdata(io_wdata),
    .rf_dbg_addr(rf_dbg_addr), .rf_dbg_data(rf_dbg_data));

  // Data memory content as a function of address; inverted outside reads
  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  assign dmem_rdata = dmem_rd_en ? mem(dmem_addr) : ~mem(dmem_addr);
  assign io_rdata = io_rd_en ? io_mem[io_addr] : ~io_mem[io_addr];

  // IO register file written by the unit
  always @(posedge sys_clk)
    if (io_wr_en)
      io_mem[io_addr] <= io_wdata;

  // Reference for shifts, rotates and nibble swap: {flags, result}
  function automatic logic [15:0] shmod(input cfse_op_t op, input logic [7:0] v, input logic [7:0] f);
    logic [7:0] r;
    logic c;
    c = f[0];
    case (op)
      logical_shift_left: {c, r} = {v, 1'b0};
      logical_shift_right: {r, c} = {1'b0, v};
      rotate_left_carry: {c, r} = {v, f[0]};
      rotate_right_carry: {r, c} = {f[0], v};
      arith_shift_right: {r, c} = {v[7], v};
      default: r = {v[3:0], v[7:4]};
    endcase
    if (op != swap_nibbles)
      f[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
    return {f, r};
  endfunction

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Offer one instruction and wait until it is taken; valid stays up
  task automatic exec(input cfse_op_t op, input logic [4:0] rd, input logic [4:0] rr,
    input logic [2:0] b, input logic [7:0] imm);
    logic rdy;
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_rd <= rd;
    instr_rr <= rr;
    instr_bit <= b;
    instr_imm <= imm;
    instr_offset <= imm[6:0];
    instr_io_addr <= rd;
    pc_exp = pc_exp + 16'h0001;
    rdy = 1'b0;
    while (!rdy)
    begin
      @(negedge sys_clk);
      rdy = instr_ready;
      @(posedge sys_clk);
    end
  endtask

  // Drain the last instruction, count stall cycles, check pc and flags
  task automatic finish(input int wexp);
    int w;
    instr_valid <= 1'b0;
    w = 0;
    @(negedge sys_clk);
    while (!instr_ready && w < 10)
    begin
      w++;
      @(negedge sys_clk);
    end
    wr_seen = io_wr_en;
    wd_seen = io_wdata;
    `CHK(w, wexp)
    `CHK(pc, pc_exp)
    `CHK(status_flags, sf_exp)
    @(posedge sys_clk);
  endtask

  task automatic rdreg(input logic [4:0] a, input logic [7:0] x);
    rf_dbg_addr <= a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(rf_dbg_data, x)
    @(posedge sys_clk);
  endtask

  task automatic loadchk(input cfse_op_t op, input logic [4:0] rd, input logic [7:0] dx,
    input logic [4:0] pa, input logic [15:0] pv);
    exec(op, rd, 5'h00, 3'h0, 8'h00);
    finish(1);
    rdreg(rd, dx);
    rdreg(pa, pv[7:0]);
    rdreg(pa + 5'h01, pv[15:8]);
  endtask

  task automatic summarize();
    if (num_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    summarize();
  end

  initial
  begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr_op = op_nop;
    {instr_rd, instr_rr, instr_bit, instr_imm, instr_offset, instr_io_addr, rf_dbg_addr} = '0;
    for (i = 0; i < 32; i++)
      io_mem[i] = 8'h00;
    io_mem[5] = 8'h5A;
    pc_exp = 16'h0000;
    sf_exp = 8'h00;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    `CHK(pc, 16'h0000)
    `CHK(status_flags, 8'h00)
    `CHK(instr_ready, 1'b1)
    @(posedge sys_clk);
    for (i = 0; i < 16; i++)
    begin
      exec(i < 8 ? status_flag_set_instr : status_flag_clear_instr, 5'h00, 5'h00, i[2:0], 8'h00);
      sf_exp[i[2:0]] = (i < 8);
      finish(0);
    end
    exec(global_irq_enable_instr, 5'h00, 5'h00, 3'h0, 8'h00);
    sf_exp[`CFSE_FLAG_I] = 1'b1;
    finish(0);
    exec(global_irq_disable_instr, 5'h00, 5'h00, 3'h0, 8'h00);
    sf_exp[`CFSE_FLAG_I] = 1'b0;
    finish(0);
    exec(load_immediate, 5'd16, 5'h00, 3'h0, 8'h81);
    exec(load_immediate, 5'd17, 5'h00, 3'h0, 8'h3C);
    exec(copy_register_pair, 5'd2, 5'd16, 3'h0, 8'h00);
    exec(copy_register, 5'd4, 5'd17, 3'h0, 8'h00);
    finish(0);
    rdreg(5'd2, 8'h81);
    rdreg(5'd3, 8'h3C);
    rdreg(5'd4, 8'h3C);
    for (p = 0; p < 2; p++)
      for (i = 0; i < 6; i++)
      begin
        exec(load_immediate, 5'd20, 5'h00, 3'h0, p == 0 ? 8'h81 : 8'h80);
        exec(p == 0 ? status_flag_set_instr : status_flag_clear_instr, 5'h00, 5'h00, 3'h0, 8'h00);
        sf_exp[`CFSE_FLAG_C] = (p == 0);
        exec(sops[i], 5'd20, 5'h00, 3'h0, 8'h00);
        e = shmod(sops[i], p == 0 ? 8'h81 : 8'h80, sf_exp);
        sf_exp = e[15:8];
        finish(0);
        rdreg(5'd20, e[7:0]);
      end
    exec(load_immediate, 5'd21, 5'h00, 3'h0, 8'h40);
    exec(store_bit_to_transfer_flag, 5'd21, 5'h00, 3'h6, 8'h00);
    sf_exp[`CFSE_FLAG_T] = 1'b1;
    finish(0);
    exec(load_immediate, 5'd22, 5'h00, 3'h0, 8'hF0);
    exec(fetch_bit_from_transfer_flag, 5'd22, 5'h00, 3'h3, 8'h00);
    finish(0);
    rdreg(5'd22, 8'hF8);
    exec(store_bit_to_transfer_flag, 5'd21, 5'h00, 3'h5, 8'h00);
    sf_exp[`CFSE_FLAG_T] = 1'b0;
    finish(0);
    for (i = 0; i < 5; i++)
      for (p = 0; p < 2; p++)
      begin
        exec(p == 1 ? status_flag_set_instr : status_flag_clear_instr, 5'h00, 5'h00, bfl[i], 8'h00);
        sf_exp[bfl[i]] = p[0];
        exec(bops[i], 5'h00, 5'h00, 3'h0, 8'h7D);
        tk = (p[0] == bwh[i]);
        if (tk == 1)
          pc_exp = pc_exp - 16'h0003;
        finish(tk);
      end
    exec(io_bit_set_instr, 5'd5, 5'h00, 3'h0, 8'h00);
    finish(1);
    `CHK(wr_seen, 1'b1)
    `CHK(wd_seen, 8'h5B)
    exec(io_bit_clear_instr, 5'd5, 5'h00, 3'h6, 8'h00);
    finish(1);
    `CHK(wd_seen, 8'h1B)
    exec(load_immediate, `CFSE_PTR_X_LO, 5'h00, 3'h0, 8'h10);
    exec(load_immediate, `CFSE_PTR_X_HI, 5'h00, 3'h0, 8'h01);
    exec(load_immediate, `CFSE_PTR_Y_LO, 5'h00, 3'h0, 8'hFF);
    exec(load_immediate, `CFSE_PTR_Y_HI, 5'h00, 3'h0, 8'h02);
    finish(0);
    loadchk(load_indirect_x, 5'd1, mem(16'h0110), `CFSE_PTR_X_LO, 16'h0110);
    loadchk(load_indirect_x_post_inc, 5'd2, mem(16'h0110), `CFSE_PTR_X_LO, 16'h0111);
    loadchk(load_indirect_x_pre_dec, 5'd3, mem(16'h0110), `CFSE_PTR_X_LO, 16'h0110);
    loadchk(load_indirect_y_post_inc, 5'd4, mem(16'h02FF), `CFSE_PTR_Y_LO, 16'h0300);
    loadchk(load_indirect_y_pre_dec, 5'd5, mem(16'h02FF), `CFSE_PTR_Y_LO, 16'h02FF);
    loadchk(load_indirect_y, 5'd6, mem(16'h02FF), `CFSE_PTR_Y_LO, 16'h02FF);
    summarize();
  end
endmodule
`undef CHK
`default_nettype wire
